// ### pkg/scp_defines.vh
// Constants for the slave configuration port control block
`ifndef SCP_DEFINES_VH
`define SCP_DEFINES_VH

// ==========================================================================
// Timing and sizes
`define SCP_CLK_PERIOD_NS 20
`define SCP_PROG_MIN_NS   500
`define SCP_PROG_MIN_CYC  ((`SCP_PROG_MIN_NS + `SCP_CLK_PERIOD_NS - 1) / `SCP_CLK_PERIOD_NS)
`define SCP_CLEAR_CYC     64
`define SCP_STARTUP_CLKS  8
`define SCP_CFG_BYTES     16
`define SCP_FIFO_DEPTH    4

// ==========================================================================
// Mode pin patterns
`define SCP_MODE_SERIAL   3'h7
`define SCP_MODE_PARALLEL 3'h6

// ==========================================================================
// Positions in the synchronised pin vector
`define SCP_SYNC_W   19
`define SCP_B_LCLK   0
`define SCP_B_PROG   1
`define SCP_B_DIN    2
`define SCP_B_CS     3
`define SCP_B_RW     4
`define SCP_B_INIT   5
`define SCP_B_DONE   6
`define SCP_B_D_LO   7
`define SCP_B_D_HI   14
`define SCP_B_M_LO   15
`define SCP_B_M_HI   17
`define SCP_B_PUDIS  18

// ==========================================================================
// Reset values
`define SCP_RST_SYNC     19'h00012
`define SCP_RST_OE_N     1'b0
`define SCP_RST_CSO_N    1'b1

`endif

// ### logic/scp_fifo.v
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps

module scp_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 4,
	parameter AW    = 2
) (
	// Clock and reset
	input  wire             clk,
	input  wire             rst_n,
	// Fill side
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	// Drain side
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);

	reg  [WIDTH-1:0] mem_q [0:DEPTH-1];
	reg  [AW:0]      wr_ptr_q;
	reg  [AW:0]      rd_ptr_q;
	wire             full;
	wire             empty;
	integer          i;

	// Extra pointer bit tells full from empty
	assign empty     = (wr_ptr_q == rd_ptr_q);
	assign full      = (wr_ptr_q[AW] != rd_ptr_q[AW]) &&
		(wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
	assign in_ready  = !full;
	assign out_valid = !empty;
	assign out_data  = mem_q[rd_ptr_q[AW-1:0]];

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_q <= {(AW+1){1'b0}};
			rd_ptr_q <= {(AW+1){1'b0}};
			for (i = 0; i < DEPTH; i = i + 1)
				mem_q[i] <= {WIDTH{1'b0}};
		end else begin
			if (in_valid && !full) begin
				mem_q[wr_ptr_q[AW-1:0]] <= in_data;
				wr_ptr_q <= wr_ptr_q + 1'b1;
			end
			if (out_ready && !empty)
				rd_ptr_q <= rd_ptr_q + 1'b1;
		end
	end

endmodule // scp_fifo

// ### logic/scp_config_port.v
// Slave configuration port control: restart, indicators, byte capture
// Summary of operation
// RULE_01: Init low while clearing; release samples mode pins
// RULE_02: CRC failure drives init low as error
// RULE_03: Done held low until successful completion
// RULE_04: Program low 500 ns restarts after release
// RULE_05: Host keeps program high to allow start
// RULE_06: Host pulses program low to reprogram
// RULE_07: Downstream chain devices strapped to mode 110
// RULE_08: Host keeps read/write select low throughout
// RULE_09: Lead asserts next chip select after own data
// RULE_10: Serial mode 111 captures bit on rising clock
// RULE_11: Host pulses program, waits init high first
// RULE_12: Host clocks until done rises or init falls
// RULE_13: Host supplies extra clocks for start-up
// RULE_14: Host holds mode pins steady at sampling
// RULE_15: After done high, mode/pull-up pins freed
// RULE_16: Pull-up pin low enables pull-ups during configuration
// RULE_17: Surrounding logic drives unused init high afterwards
// RULE_18: Busy high means host holds data longer
// RULE_19: Parallel mode captures byte on rising clock
// RULE_20: Clock and data ignored while memory clears
`timescale 1ns/1ps
`include "scp_defines.vh"

module scp_config_port #(
	parameter CLEAR_CYC    = `SCP_CLEAR_CYC,
	parameter STARTUP_CLKS = `SCP_STARTUP_CLKS,
	parameter CFG_BYTES    = `SCP_CFG_BYTES,
	parameter FIFO_DEPTH   = `SCP_FIFO_DEPTH
) (
	// System clock and reset
	input  wire       CLK_SYS,
	input  wire       RESETN,
	// Configuration pins from the host
	input  wire       CONFIG_CLOCK,
	input  wire       PROGRAM_RESTART_N,
	input  wire       SERIAL_DIN,
	input  wire [7:0] PAR_DATA,
	input  wire       CHIP_SELECT_N,
	input  wire       READ_WRITE_SELECT_N,
	input  wire [2:0] MODE_PINS,
	input  wire       PULLUP_DISABLE_PIN,
	// Open-drain initialization indicator
	input  wire       INIT_IN,
	output wire       INIT_OUT,
	output wire       INIT_OE_N,
	// Open-drain done indicator
	input  wire       DONE_IN,
	output wire       DONE_OUT,
	output wire       DONE_OE_N,
	// Chain and flow outputs
	output wire       BUSY,
	output wire       NEXT_CHIP_SELECT_OUT_N,
	// Device-internal status
	output wire       PULLUP_ENABLE,
	output wire       USER_IO_FREE,
	output wire [2:0] MODE_LATCHED,
	input  wire       CRC_ERROR,
	// Configuration byte stream
	output wire [7:0] CFG_DATA,
	output wire       CFG_VALID,
	input  wire       CFG_READY
);

	// ======================================================================
	// Constants
	localparam [2:0] ST_HOLD    = 3'h0;
	localparam [2:0] ST_CLEAR   = 3'h1;
	localparam [2:0] ST_WAIT    = 3'h2;
	localparam [2:0] ST_LOAD    = 3'h3;
	localparam [2:0] ST_STARTUP = 3'h4;
	localparam [2:0] ST_DONE    = 3'h5;
	localparam [2:0] ST_ERROR   = 3'h6;

	// Plain integers: compared or passed down as a parameter, never stored in a narrower register
	localparam PROG_MIN   = `SCP_PROG_MIN_CYC;
	localparam CLEAR_LAST = CLEAR_CYC - 1;
	localparam STARTUP_N  = STARTUP_CLKS;
	localparam BYTES_LAST = CFG_BYTES - 1;
	localparam        FIFO_AW    = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;

	// ======================================================================
	// Declarations
	wire [`SCP_SYNC_W-1:0] pins_raw;
	reg  [`SCP_SYNC_W-1:0] sync1_q;
	reg  [`SCP_SYNC_W-1:0] sync2_q;
	reg  [`SCP_SYNC_W-1:0] sync3_q;
	reg  [`SCP_SYNC_W-1:0] filt_q;
	reg  [`SCP_SYNC_W-1:0] filt_d;
	reg                    lclk_prev_q;
	wire                   lclk_rise;
	wire                   prog_n;
	wire                   din;
	wire                   cs_n;
	wire                   rw_n;
	wire                   init_pin;
	wire                   done_pin;
	wire [7:0]             pdata;

	reg  [2:0]             state_q;
	reg  [2:0]             state_d;
	reg  [15:0]            prog_cnt_q;
	reg  [15:0]            cnt_q;
	reg  [15:0]            cnt_d;
	reg  [15:0]            byte_cnt_q;
	reg  [7:0]             shift_q;
	reg  [2:0]             bit_cnt_q;
	reg  [2:0]             mode_q;
	reg                    pudis_q;
	reg                    init_oe_n_q;
	reg                    done_oe_n_q;
	reg                    cso_n_q;
	reg                    io_free_q;
	reg                    wr_valid_q;
	reg  [7:0]             wr_data_q;

	wire                   fifo_in_ready;
	wire                   fifo_out_valid;
	wire                   is_serial;
	wire                   is_parallel;
	wire                   prog_armed;
	wire                   par_take;
	wire                   ser_byte;
	wire                   push;
	wire                   last_byte;

	// ======================================================================
	// Pin synchroniser, three stages with agreement filter
	assign pins_raw = {PULLUP_DISABLE_PIN, MODE_PINS, PAR_DATA, DONE_IN,
		INIT_IN, READ_WRITE_SELECT_N, CHIP_SELECT_N, SERIAL_DIN,
		PROGRAM_RESTART_N, CONFIG_CLOCK};

	always @* begin
		filt_d = (sync2_q & ~(sync2_q ^ sync3_q)) |
			(filt_q & (sync2_q ^ sync3_q));
	end

	always @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			sync1_q     <= `SCP_RST_SYNC;
			sync2_q     <= `SCP_RST_SYNC;
			sync3_q     <= `SCP_RST_SYNC;
			filt_q      <= `SCP_RST_SYNC;
			lclk_prev_q <= 1'b0;
		end else begin
			sync1_q     <= pins_raw;
			sync2_q     <= sync1_q;
			sync3_q     <= sync2_q;
			filt_q      <= filt_d;
			lclk_prev_q <= filt_q[`SCP_B_LCLK];
		end
	end

	assign lclk_rise = filt_q[`SCP_B_LCLK] && !lclk_prev_q;
	assign prog_n    = filt_q[`SCP_B_PROG];
	assign din       = filt_q[`SCP_B_DIN];
	assign cs_n      = filt_q[`SCP_B_CS];
	assign rw_n      = filt_q[`SCP_B_RW];
	assign init_pin  = filt_q[`SCP_B_INIT];
	assign done_pin  = filt_q[`SCP_B_DONE];
	assign pdata     = filt_q[`SCP_B_D_HI:`SCP_B_D_LO];

	// ======================================================================
	// Capture decode
	assign is_serial   = (mode_q == `SCP_MODE_SERIAL);
	assign is_parallel = (mode_q == `SCP_MODE_PARALLEL);
	assign prog_armed  = (prog_cnt_q >= PROG_MIN);
	// Only the load state captures from the data pins
	assign par_take  = (state_q == ST_LOAD) && is_parallel && lclk_rise &&
		!cs_n && !rw_n && fifo_in_ready; // see RULE_19 see RULE_20
	assign ser_byte  = (state_q == ST_LOAD) && is_serial && lclk_rise &&
		(bit_cnt_q == 3'h7); // see RULE_10 see RULE_20
	assign push      = par_take || (ser_byte && fifo_in_ready);
	assign last_byte = (byte_cnt_q == BYTES_LAST);

	// ======================================================================
	// Sequencer
	always @* begin
		state_d = state_q;
		cnt_d   = cnt_q;
		case (state_q)
			ST_HOLD: begin
				cnt_d = 16'h0000;
				if (prog_n)
					state_d = ST_CLEAR; // see RULE_04
			end
			ST_CLEAR: begin
				cnt_d = cnt_q + 16'h0001;
				if (cnt_q >= CLEAR_LAST)
					state_d = ST_WAIT; // see RULE_01
			end
			ST_WAIT: begin
				// Another device may still hold the shared line low
				cnt_d = 16'h0000;
				if (init_pin)
					state_d = ST_LOAD;
			end
			ST_LOAD: begin
				if (CRC_ERROR)
					state_d = ST_ERROR; // see RULE_02
				else if (ser_byte && !fifo_in_ready)
					state_d = ST_ERROR;
				else if (push && last_byte)
					state_d = ST_STARTUP;
			end
			ST_STARTUP: begin
				if (lclk_rise && cnt_q < STARTUP_N)
					cnt_d = cnt_q + 16'h0001;
				if (CRC_ERROR)
					state_d = ST_ERROR; // see RULE_02
				else if (cnt_q >= STARTUP_N && !fifo_out_valid)
					state_d = ST_DONE; // see RULE_03
			end
			ST_DONE: begin
				cnt_d = 16'h0000;
			end
			ST_ERROR: begin
				cnt_d = 16'h0000;
			end
			default: begin
				state_d = ST_HOLD;
				cnt_d   = 16'h0000;
			end
		endcase
		// A long enough program pulse overrides every state
		if (!prog_n && prog_armed)
			state_d = ST_HOLD; // see RULE_04
	end

	always @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			state_q    <= ST_CLEAR;
			cnt_q      <= 16'h0000;
			prog_cnt_q <= 16'h0000;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			// Short glitches on the program pin are ignored
			if (prog_n)
				prog_cnt_q <= 16'h0000;
			else if (!prog_armed)
				prog_cnt_q <= prog_cnt_q + 16'h0001; // see RULE_04
		end
	end

	// ======================================================================
	// Mode and pull-up sampling at init release
	always @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			mode_q  <= 3'h0;
			pudis_q <= 1'b1;
		end else if (state_q == ST_WAIT && init_pin) begin
			mode_q  <= filt_q[`SCP_B_M_HI:`SCP_B_M_LO]; // see RULE_01
			pudis_q <= filt_q[`SCP_B_PUDIS]; // see RULE_16
		end
	end

	// ======================================================================
	// Byte assembly and stream push
	always @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			shift_q    <= 8'h00;
			bit_cnt_q  <= 3'h0;
			byte_cnt_q <= 16'h0000;
			wr_valid_q <= 1'b0;
			wr_data_q  <= 8'h00;
		end else begin
			wr_valid_q <= push;
			if (state_q != ST_LOAD && state_q != ST_STARTUP) begin
				bit_cnt_q  <= 3'h0;
				byte_cnt_q <= 16'h0000;
			end else if (state_q == ST_LOAD && is_serial && lclk_rise) begin
				shift_q   <= {shift_q[6:0], din}; // see RULE_10
				bit_cnt_q <= bit_cnt_q + 3'h1;
			end
			if (ser_byte)
				wr_data_q <= {shift_q[6:0], din};
			else if (par_take)
				wr_data_q <= pdata; // see RULE_19
			if (push)
				byte_cnt_q <= byte_cnt_q + 16'h0001;
		end
	end

	scp_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH),
		.AW    (FIFO_AW)
	) u_fifo (
		.clk       (CLK_SYS),
		.rst_n     (RESETN),
		.in_valid  (wr_valid_q),
		.in_ready  (fifo_in_ready),
		.in_data   (wr_data_q),
		.out_valid (fifo_out_valid),
		.out_ready (CFG_READY),
		.out_data  (CFG_DATA)
	);

	// ======================================================================
	// Indicator and chain outputs
	always @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			init_oe_n_q <= `SCP_RST_OE_N;
			done_oe_n_q <= `SCP_RST_OE_N;
			cso_n_q     <= `SCP_RST_CSO_N;
			io_free_q   <= 1'b0;
		end else begin
			init_oe_n_q <= !(state_d == ST_HOLD || state_d == ST_CLEAR ||
				state_d == ST_ERROR); // see RULE_01 see RULE_02
			done_oe_n_q <= (state_d == ST_DONE); // see RULE_03
			if (state_d == ST_HOLD || state_d == ST_CLEAR)
				cso_n_q <= 1'b1;
			else if (push && last_byte)
				cso_n_q <= 1'b0; // see RULE_09
			io_free_q <= (state_d == ST_DONE) && done_pin; // see RULE_15
		end
	end

	// Both open-drain pins only ever pull low
	assign INIT_OUT  = 1'b0;
	assign INIT_OE_N = init_oe_n_q;
	assign DONE_OUT  = 1'b0;
	assign DONE_OE_N = done_oe_n_q;

	// Busy in parallel load while the stream buffer cannot take another byte
	assign BUSY = (state_q == ST_LOAD) && is_parallel &&
		!fifo_in_ready; // see RULE_18

	assign NEXT_CHIP_SELECT_OUT_N = cso_n_q;
	assign PULLUP_ENABLE = !io_free_q && !pudis_q; // see RULE_16
	assign USER_IO_FREE  = io_free_q;
	assign MODE_LATCHED  = mode_q;
	assign CFG_VALID     = fifo_out_valid;

endmodule // scp_config_port

// ### dv/scp_checker.sv
// Checker of the configuration port control outputs
`timescale 1ns/1ps

module scp_checker #(
	parameter CLEAR_CYC = 64
) (
	// Clock and reset
	input wire       CLK_SYS,
	input wire       RESETN,
	// Open-drain indicators
	input wire       INIT_IN,
	input wire       INIT_OUT,
	input wire       INIT_OE_N,
	input wire       DONE_IN,
	input wire       DONE_OUT,
	input wire       DONE_OE_N,
	// Chain, flow and status
	input wire       BUSY,
	input wire       NEXT_CHIP_SELECT_OUT_N,
	input wire       PULLUP_ENABLE,
	input wire       USER_IO_FREE,
	input wire [2:0] MODE_LATCHED,
	// Byte stream
	input wire [7:0] CFG_DATA,
	input wire       CFG_VALID,
	input wire       CFG_READY
);
	// ==========================================================
	// Helper: edges spent pulling the init wire low
	reg [15:0] low_cnt_q;
	always @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN)
			low_cnt_q <= 16'h0000;
		else if (INIT_OE_N)
			low_cnt_q <= 16'h0000;
		else if (low_cnt_q != 16'hFFFF)
			low_cnt_q <= low_cnt_q + 16'h0001;
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!RESETN);

	AST_OD_LOW: assert property (
		INIT_OUT == 1'b0 && DONE_OUT == 1'b0) else $error("open-drain level");
	AST_CLEAR_LEN: assert property (
		$rose(INIT_OE_N) |-> low_cnt_q >= CLEAR_CYC - 1)
		else $error("clearing too short");
	AST_DONE_ORDER: assert property (
		$rose(DONE_OE_N) |-> !NEXT_CHIP_SELECT_OUT_N && INIT_OE_N && !CFG_VALID)
		else $error("done released early");
	AST_CSO_FELL: assert property (
		$fell(NEXT_CHIP_SELECT_OUT_N) |-> INIT_OE_N && !DONE_OE_N)
		else $error("chip select out at wrong time");
	AST_FREE_ROSE: assert property (
		$rose(USER_IO_FREE) |-> DONE_OE_N && $past(DONE_IN))
		else $error("user io freed before done");
	AST_PULLUP: assert property (
		USER_IO_FREE |-> !PULLUP_ENABLE && DONE_OE_N)
		else $error("pull-ups after done");
	AST_BUSY_PAR: assert property (
		BUSY |-> INIT_OE_N && MODE_LATCHED == 3'h6 && CFG_VALID)
		else $error("busy outside parallel load");
	AST_HOLD_HEAD: assert property (
		CFG_VALID && !CFG_READY && INIT_OE_N |=> !CFG_VALID || $stable(CFG_DATA))
		else $error("stream head changed");
	AST_MODE_LATCH: assert property (
		$changed(MODE_LATCHED) && INIT_OE_N |-> !DONE_OE_N && $past(INIT_IN))
		else $error("mode latched off init release");
endmodule // scp_checker

bind scp_config_port scp_checker #(.CLEAR_CYC(CLEAR_CYC)) CHK (
	.CLK_SYS(CLK_SYS), .RESETN(RESETN), .INIT_IN(INIT_IN),
	.INIT_OUT(INIT_OUT), .INIT_OE_N(INIT_OE_N), .DONE_IN(DONE_IN),
	.DONE_OUT(DONE_OUT), .DONE_OE_N(DONE_OE_N), .BUSY(BUSY),
	.NEXT_CHIP_SELECT_OUT_N(NEXT_CHIP_SELECT_OUT_N),
	.PULLUP_ENABLE(PULLUP_ENABLE), .USER_IO_FREE(USER_IO_FREE),
	.MODE_LATCHED(MODE_LATCHED), .CFG_DATA(CFG_DATA),
	.CFG_VALID(CFG_VALID), .CFG_READY(CFG_READY));

// ### dv/scp_host.sv
// Host model driving the configuration pins
`timescale 1ns/1ps

module scp_host (
	// Clock
	input  wire        CLK_SYS,
	// Configuration pins
	output logic       CONFIG_CLOCK,
	output logic       PROGRAM_RESTART_N,
	output logic       SERIAL_DIN,
	output logic [7:0] PAR_DATA,
	output logic       CHIP_SELECT_N,
	output logic       READ_WRITE_SELECT_N,
	output logic [2:0] MODE_PINS,
	output logic       PULLUP_DISABLE_PIN
);
	initial begin
		CONFIG_CLOCK = 1'b0;
		PROGRAM_RESTART_N = 1'b1;
		SERIAL_DIN = 1'b0;
		PAR_DATA = 8'h00;
		CHIP_SELECT_N = 1'b1;
		READ_WRITE_SELECT_N = 1'b0;
		MODE_PINS = 3'h7;
		PULLUP_DISABLE_PIN = 1'b0;
	end

	// ==========================================================
	// Link clock: 160 ns, data set a half period before the rise
	task automatic clk_pulse();
		repeat (4) @(posedge CLK_SYS);
		CONFIG_CLOCK <= 1'b1;
		repeat (4) @(posedge CLK_SYS);
		CONFIG_CLOCK <= 1'b0;
	endtask
	task automatic ser_byte(input logic [7:0] b);
		@(posedge CLK_SYS);
		for (int i = 7; i >= 0; i--) begin
			SERIAL_DIN <= b[i];
			clk_pulse();
		end
		// Stale data must not look valid once the hold has run out
		SERIAL_DIN <= ~SERIAL_DIN;
	endtask
	task automatic par_byte(input logic [7:0] b);
		@(posedge CLK_SYS);
		PAR_DATA <= b;
		CHIP_SELECT_N <= 1'b0;
		clk_pulse();
		PAR_DATA <= ~PAR_DATA;
	endtask
	// Byte offered with the given select levels, then back to writing
	task automatic par_refused(input logic [7:0] b, input logic cs,
		input logic rw);
		@(posedge CLK_SYS);
		PAR_DATA <= b;
		CHIP_SELECT_N <= cs;
		READ_WRITE_SELECT_N <= rw;
		clk_pulse();
		CHIP_SELECT_N <= 1'b0;
		READ_WRITE_SELECT_N <= 1'b0;
	endtask
	task automatic clocks(input int n);
		repeat (n) clk_pulse();
	endtask
	task automatic prog(input int n);
		@(posedge CLK_SYS);
		PROGRAM_RESTART_N <= 1'b0;
		repeat (n) @(posedge CLK_SYS);
		PROGRAM_RESTART_N <= 1'b1;
	endtask
	task automatic strap(input logic [2:0] m, input logic pu);
		@(posedge CLK_SYS);
		MODE_PINS <= m;
		PULLUP_DISABLE_PIN <= pu;
	endtask
endmodule // scp_host

// ### dv/tb_top.sv
// Top testbench for the configuration port control block
`timescale 1ns/1ps

module tb_top;
	localparam int CLR = 32;
	localparam int SUC = 2;
	localparam int NBY = 6;
	logic       clk_sys, resetn, crc_error, cfg_ready;
	wire        lclk, prog_n, din, cs_n, rw_n, pu_pin;
	wire  [7:0] par_data, cfg_data;
	wire  [2:0] mode, mode_lat;
	wire        init_out, init_oe_n, done_out, done_oe_n, init_w, done_w;
	wire        busy, cso_n, pu_en, io_free, cfg_valid;
	int         fails, checks_done, cyc;
	logic [7:0] pat [0:5] = '{8'hA5, 8'h3C, 8'h81, 8'h7E, 8'h00, 8'hFF};

	// Pull-ups on the shared open-drain wires
	assign init_w = init_oe_n ? 1'b1 : init_out;
	assign done_w = done_oe_n ? 1'b1 : done_out;

	scp_host HOST (.CLK_SYS(clk_sys), .CONFIG_CLOCK(lclk),
		.PROGRAM_RESTART_N(prog_n), .SERIAL_DIN(din), .PAR_DATA(par_data),
		.CHIP_SELECT_N(cs_n), .READ_WRITE_SELECT_N(rw_n), .MODE_PINS(mode),
		.PULLUP_DISABLE_PIN(pu_pin));
	scp_config_port #(.CLEAR_CYC(CLR), .STARTUP_CLKS(SUC), .CFG_BYTES(NBY),
		.FIFO_DEPTH(4)) DUT (.CLK_SYS(clk_sys), .RESETN(resetn),
		.CONFIG_CLOCK(lclk), .PROGRAM_RESTART_N(prog_n), .SERIAL_DIN(din),
		.PAR_DATA(par_data), .CHIP_SELECT_N(cs_n),
		.READ_WRITE_SELECT_N(rw_n), .MODE_PINS(mode),
		.PULLUP_DISABLE_PIN(pu_pin), .INIT_IN(init_w), .INIT_OUT(init_out),
		.INIT_OE_N(init_oe_n), .DONE_IN(done_w), .DONE_OUT(done_out),
		.DONE_OE_N(done_oe_n), .BUSY(busy), .NEXT_CHIP_SELECT_OUT_N(cso_n),
		.PULLUP_ENABLE(pu_en), .USER_IO_FREE(io_free),
		.MODE_LATCHED(mode_lat), .CRC_ERROR(crc_error), .CFG_DATA(cfg_data),
		.CFG_VALID(cfg_valid), .CFG_READY(cfg_ready));

	// ==========================================================
	// Comparison and helper tasks
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chkb(input logic got, input logic exp);
		chk({7'h00, got}, {7'h00, exp});
	endtask
	task automatic wrap_up();
		$display("Checks %0d, mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Pins reach the filtered vector four edges late
	task automatic settle();
		repeat (5) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask
	task automatic wait_init(input logic v);
		int n;
		n = 0;
		while (init_w !== v && n < 400) begin
			@(negedge clk_sys);
			n++;
		end
		chkb(init_w, v);
	endtask
	task automatic drain(input logic [7:0] exp);
		settle();
		chkb(cfg_valid, 1'b1);
		chk(cfg_data, exp);
		@(posedge clk_sys);
		cfg_ready <= 1'b1;
		@(posedge clk_sys);
		cfg_ready <= 1'b0;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_power_up();
		int n;
		n = 0;
		@(negedge clk_sys);
		chkb(done_oe_n, 1'b0);
		chkb(cso_n, 1'b1);
		while (init_oe_n !== 1'b1 && n < 400) begin
			@(negedge clk_sys);
			n++;
		end
		chkb(n >= CLR - 1 && n <= CLR + 3, 1'b1);
		wait_init(1'b1);
		settle();
		chk({5'h00, mode_lat}, 8'h07);
		chkb(pu_en, 1'b1);
	endtask
	task automatic t_serial();
		HOST.ser_byte(pat[0]);
		HOST.ser_byte(pat[1]);
		drain(pat[0]);
		drain(pat[1]);
		for (int i = 2; i < NBY; i++)
			HOST.ser_byte(pat[i]);
		settle();
		chkb(cso_n, 1'b0);
		chkb(done_oe_n, 1'b0);
		for (int i = 2; i < NBY; i++)
			drain(pat[i]);
		HOST.clocks(SUC + 2);
		settle();
		chkb(done_oe_n, 1'b1);
		chkb(io_free, 1'b1);
		chkb(pu_en, 1'b0);
	endtask
	task automatic t_short_prog();
		HOST.prog(10);
		repeat (40) @(negedge clk_sys);
		chkb(done_oe_n, 1'b1);
		chkb(init_oe_n, 1'b1);
	endtask
	task automatic t_restart_par();
		HOST.strap(3'h6, 1'b1);
		HOST.prog(30);
		settle();
		chkb(done_oe_n, 1'b0);
		chkb(init_oe_n, 1'b0);
		chkb(io_free, 1'b0);
		HOST.par_byte(8'h99);
		settle();
		chkb(cfg_valid, 1'b0);
		wait_init(1'b1);
		settle();
		chk({5'h00, mode_lat}, 8'h06);
		chkb(pu_en, 1'b0);
		// Read selected or chip deselected: nothing may land
		HOST.par_refused(8'h5A, 1'b0, 1'b1);
		HOST.par_refused(8'hC3, 1'b1, 1'b0);
		settle();
		chkb(cfg_valid, 1'b0);
		chkb(cso_n, 1'b1);
		for (int i = 0; i < 4; i++)
			HOST.par_byte(pat[i]);
		settle();
		chkb(busy, 1'b1);
		HOST.par_byte(pat[4]);
		drain(pat[0]);
		settle();
		chkb(busy, 1'b0);
		HOST.par_byte(pat[4]);
		for (int i = 1; i < 5; i++)
			drain(pat[i]);
		HOST.par_byte(pat[5]);
		settle();
		chkb(cso_n, 1'b0);
		drain(pat[5]);
		HOST.clocks(SUC + 2);
		settle();
		chkb(done_oe_n, 1'b1);
	endtask
	task automatic t_crc();
		HOST.strap(3'h7, 1'b0);
		HOST.prog(30);
		wait_init(1'b0);
		wait_init(1'b1);
		settle();
		@(posedge clk_sys);
		crc_error <= 1'b1;
		@(posedge clk_sys);
		crc_error <= 1'b0;
		@(negedge clk_sys);
		chkb(init_w, 1'b0);
		HOST.clocks(2);
		chkb(init_oe_n, 1'b0);
		chkb(done_oe_n, 1'b0);
	endtask

	// ==========================================================
	// Clock, sequence and hang guard
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	initial begin
		resetn = 1'b0;
		crc_error = 1'b0;
		cfg_ready = 1'b0;
		fails = 0;
		checks_done = 0;
		cyc = 0;
		repeat (12) @(posedge clk_sys);
		resetn <= 1'b1;
		t_power_up();
		t_serial();
		t_short_prog();
		t_restart_par();
		t_crc();
		wrap_up();
	end
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 10000) begin
			fails++;
			wrap_up();
		end
	end
endmodule // tb_top
